// ===== rtl/block_advance_pkg.sv
// package of register map, field positions and encodings for the block advance gate
// assumes a 32-bit apb slave and bit-mapped signal bytes toward the machine logic
package block_advance_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CONFIG  = 8'h00;
	localparam logic [7:0] OFS_CMD     = 8'h04;
	localparam logic [7:0] OFS_DWELL   = 8'h08;
	localparam logic [7:0] OFS_INPOS   = 8'h0C;
	localparam logic [7:0] OFS_MOTION  = 8'h10;
	localparam logic [7:0] OFS_DETACH  = 8'h14;
	localparam logic [7:0] OFS_STATUS  = 8'h18;
	localparam logic [7:0] OFS_FEED    = 8'h1C;
	localparam logic [7:0] OFS_SCALED  = 8'h20;

	// ----------------------------------------------------------------
	// config fields
	// ----------------------------------------------------------------
	localparam int CFG_GLOBAL_IL_DIS = 0;
	localparam int CFG_AXIS_IL_DIS   = 2;
	localparam int CFG_DIR_IL_DIS    = 3;
	localparam int CFG_FAST_SEL      = 7;
	localparam int CFG_MULTI_M_EN    = 8;
	localparam int CFG_DETACH_EN     = 9;
	localparam int CFG_ARRIVAL_EN    = 10;
	localparam int CFG_TURNING       = 11;
	localparam logic [11:0] CFG_RESET = 12'h000;

	// command fields: issue bits m,s,t,b,m2,m3 then block start
	localparam int CMD_START    = 8;
	localparam int DETACH_PARAM_BIT = 7;
	localparam int MOTION_POSITIONING = 16;

	// aux code index inside the handshake vector
	localparam int AUX_M  = 0;
	localparam int AUX_S  = 1;
	localparam int AUX_T  = 2;
	localparam int AUX_B  = 3;
	localparam int AUX_M2 = 4;
	localparam int AUX_M3 = 5;

	// signal byte bit positions
	localparam int BIT_M = 0;
	localparam int BIT_S = 2;
	localparam int BIT_T = 3;
	localparam int BIT_B_DONE = 4;
	localparam int BIT_B_MILL = 7;
	localparam int BIT_B_TURN = 4;
	localparam int BIT_M2 = 4;
	localparam int BIT_M3 = 5;
	localparam int BIT_START_LOCK = 1;
	localparam int BIT_GLOBAL_IL = 0;
	localparam int BIT_AT_SPEED = 4;
	localparam int BIT_TURN_DIR_LO = 2;

	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	localparam logic [7:0] OVR_ALL_ONES = 8'hFF;
	localparam logic [7:0] OVR_ZERO     = 8'h00;
	localparam logic [6:0] PCT_FULL     = 7'h64;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_ADV  = 2'b11
	} blk_state_t;

endpackage

// ===== rtl/aux_hs_if.sv
// interface bundle between the block gate and its aux code handshake tracker
// assumes one clock domain shared by both modules
interface aux_hs_if;
	logic [5:0] issue;
	logic       fast_sel;
	logic       multi_en;
	logic       done_normal;
	logic [5:0] done;
	logic [5:0] strobe;
	logic       busy;

	modport gate    (output issue, fast_sel, multi_en, done_normal, done, input strobe, busy);
	modport tracker (input issue, fast_sel, multi_en, done_normal, done, output strobe, busy);
endinterface

// ===== rtl/aux_handshake.sv
// aux code strobe and completion tracker, normal and fast handshake
// assumes issue pulses come from the block gate and done levels are synchronous
module aux_handshake
	import block_advance_pkg::*;
(
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	// link to gate
	aux_hs_if.tracker hs
);

	logic [5:0] strobe_ff, nxt_strobe;
	logic       pend_ff, nxt_pend;
	logic       done_prev_ff, nxt_done_prev;
	logic [5:0] code_mask;

	// ----------------------------------------------------------------
	// strobe and pending logic
	// ----------------------------------------------------------------
	// second and third m codes only live when multi m is enabled
	always_comb begin
		code_mask = 6'h0F;
		if (hs.multi_en) begin
			code_mask = 6'h3F;
		end
		nxt_done_prev = hs.done_normal;
		nxt_strobe    = strobe_ff;
		nxt_pend      = pend_ff;
		if (hs.fast_sel) begin
			// each issue flips its strobe; done must follow to the same level
			nxt_strobe = strobe_ff ^ (hs.issue & code_mask);
			nxt_pend   = 1'b0;
		end else begin
			// fall of the single finish ends every open code
			if (done_prev_ff && !hs.done_normal) begin
				nxt_strobe = 6'h00;
				nxt_pend   = 1'b0;
			end
			if (|(hs.issue & code_mask)) begin
				nxt_strobe = nxt_strobe | (hs.issue & code_mask);
				nxt_pend   = 1'b1;
			end
		end
	end

	// register the tracker state
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			strobe_ff    <= 6'h00;
			pend_ff      <= 1'b0;
			done_prev_ff <= 1'b0;
		end else begin
			strobe_ff    <= nxt_strobe;
			pend_ff      <= nxt_pend;
			done_prev_ff <= nxt_done_prev;
		end
	end

	// fast: code ended only when done and strobe agree; normal: when pending clears
	assign hs.strobe = strobe_ff;
	assign hs.busy   = hs.fast_sel ? |((strobe_ff ^ hs.done) & code_mask) : pend_ff;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_fast_toggle_m: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(hs.fast_sel && $past(hs.fast_sel) && $past(hs.issue[AUX_M]))
		|-> (strobe_ff[AUX_M] != $past(strobe_ff[AUX_M])))
		else $error("fast m strobe did not toggle on issue");
	a_normal_fall_end: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!hs.fast_sel && done_prev_ff && !hs.done_normal && hs.issue == 6'h00) |=> !pend_ff)
		else $error("normal finish fall did not end code");
	a_multi_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!hs.multi_en && !$past(strobe_ff[AUX_M2]) && $past(!hs.multi_en)) |-> !strobe_ff[AUX_M2])
		else $error("second m strobe issued while disabled");
endmodule

// ===== rtl/block_advance_gate.sv
// block advance gate: holds the next block until every wait condition clears
// assumes apb from the nc core and synchronous signal bytes from the machine logic
// How it works
// - config bit picks normal or fast handshake
// - normal: finish falling ends code, next block
// - strobes m0 s2 t3, b bit7 milling
// - turning places b strobe at bit4
// - second, third m strobes bits 4, 5
// - extra m codes only when enabled
// - fast: ended when done equals strobe
// - positioning waits for error within width
// - hold block during dwell
// - inverted override byte, ones or zeros stop
// - optional fine override, same encoding
// - turning: start lock blocks start
// - cleared config bits enable each interlock
// - global interlock low halts motion
// - axis interlock low on a moving axis halts motion
// - milling direction interlocks axes one-four
// - turning direction interlocks manual only
// - detach enabled reports detached axes
// - detach by request or axis parameter
// - arrival check waits for spindle speed
module block_advance_gate
	import block_advance_pkg::*;
#(
	parameter int NUM_AXES = 8,
	parameter bit FINE_OVR_FITTED = 1'b0
)
(
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// apb slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic             o_pready,
	output logic [31:0]      o_prdata,
	output logic             o_pslverr,
	// machine logic input bytes
	input  wire logic        i_aux_done_normal,
	input  wire logic [7:0]  i_code_done_byte,
	input  wire logic [7:0]  i_multi_done_byte,
	input  wire logic [7:0]  i_start_byte,
	input  wire logic [7:0]  i_feed_override_n,
	input  wire logic [7:0]  i_fine_override_n,
	input  wire logic [7:0]  i_interlock_byte,
	input  wire logic [7:0]  i_axis_interlock_n,
	input  wire logic [7:0]  i_dir_plus_byte,
	input  wire logic [7:0]  i_dir_minus_byte,
	input  wire logic [7:0]  i_turn_dir_byte,
	input  wire logic [7:0]  i_axis_detach_req,
	input  wire logic [7:0]  i_spindle_byte,
	// motion side
	input  wire logic        i_manual_mode,
	input  wire logic [15:0] i_pos_error,
	// machine logic output bytes
	output logic [7:0]       o_strobe_byte,
	output logic [7:0]       o_multi_strobe_byte,
	output logic [7:0]       o_axis_detached_flag,
	// block sequencing
	output logic             o_block_advance,
	output logic             o_motion_hold
);

	// axis masks and signal bytes serve at most eight axes
	if (NUM_AXES < 1 || NUM_AXES > 8) begin : g_axes_check
		$error("NUM_AXES must be 1 to 8");
	end

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// active-low override byte to percent; both ends of the code mean zero
	function automatic logic [7:0] ovr_pct(input logic [7:0] code_n);
		if (code_n == OVR_ALL_ONES || code_n == OVR_ZERO) begin
			ovr_pct = 8'h00;
		end else begin
			ovr_pct = ~code_n;
		end
	endfunction

	// any axis selected whose bit is asserted
	function automatic logic hit(input logic [7:0] axes, input logic [7:0] bits);
		hit = |(axes & bits);
	endfunction

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	aux_hs_if hs ();

	logic [11:0] cfg_ff, nxt_cfg;
	logic [31:0] dwell_ff, nxt_dwell;
	logic [15:0] inpos_ff, nxt_inpos;
	logic [16:0] motion_ff, nxt_motion;
	logic [7:0]  detach_par_ff, nxt_detach_par;
	logic [15:0] feed_ff, nxt_feed;
	logic [31:0] scaled_ff, nxt_scaled;
	logic        pready_ff, nxt_pready;
	logic [31:0] prdata_ff, nxt_prdata;
	logic        pslverr_ff, nxt_pslverr;
	logic [5:0]  issue_ff, nxt_issue;
	logic        start_req;
	blk_state_t  state_ff, nxt_state;
	logic [7:0]  strobe_byte_ff, nxt_strobe_byte;
	logic [7:0]  multi_byte_ff, nxt_multi_byte;
	logic [7:0]  detached_ff, nxt_detached;
	logic        advance_ff, nxt_advance;
	logic        hold_ff, nxt_hold;
	logic [7:0]  wait_vec;
	logic [7:0]  axis_mask, moving, minus_dir, plus_dir;
	logic [7:0]  dir_plus_il, dir_minus_il;
	logic [7:0]  pct_main, pct_fine;
	logic        il_halt, ovr_zero, start_lock, in_pos, dwell_busy, speed_wait, detach_wait;
	logic        wr_en, rd_en;

	// ----------------------------------------------------------------
	// handshake tracker hookup
	// ----------------------------------------------------------------
	assign hs.issue       = issue_ff;
	assign hs.fast_sel    = cfg_ff[CFG_FAST_SEL];
	assign hs.multi_en    = cfg_ff[CFG_MULTI_M_EN];
	assign hs.done_normal = i_aux_done_normal;
	assign hs.done        = {i_multi_done_byte[BIT_M3], i_multi_done_byte[BIT_M2],
		i_code_done_byte[BIT_B_DONE], i_code_done_byte[BIT_T],
		i_code_done_byte[BIT_S], i_code_done_byte[BIT_M]};

	aux_handshake u_aux (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.hs      (hs.tracker)
	);

	// ----------------------------------------------------------------
	// wait conditions
	// ----------------------------------------------------------------
	always_comb begin
		axis_mask  = 8'hFF >> (8 - NUM_AXES);
		moving     = motion_ff[7:0] & axis_mask;
		minus_dir  = motion_ff[15:8];
		plus_dir   = ~motion_ff[15:8];
		dir_plus_il  = {4'h0, i_dir_plus_byte[3:0]};
		dir_minus_il = {4'h0, i_dir_minus_byte[3:0]};
		if (cfg_ff[CFG_TURNING]) begin
			// turning direction interlocks only act in manual operation
			dir_plus_il  = 8'h00;
			dir_minus_il = 8'h00;
			if (i_manual_mode) begin
				dir_plus_il  = {6'h00, i_turn_dir_byte[BIT_TURN_DIR_LO + 2], i_turn_dir_byte[BIT_TURN_DIR_LO]};
				dir_minus_il = {6'h00, i_turn_dir_byte[BIT_TURN_DIR_LO + 3], i_turn_dir_byte[BIT_TURN_DIR_LO + 1]};
			end
		end
		// each interlock acts only while its disable bit is clear
		il_halt = (!cfg_ff[CFG_GLOBAL_IL_DIS] && !i_interlock_byte[BIT_GLOBAL_IL])
			|| (!cfg_ff[CFG_AXIS_IL_DIS] && hit(moving, ~i_axis_interlock_n))
			|| (!cfg_ff[CFG_DIR_IL_DIS] && (hit(moving & plus_dir, dir_plus_il)
			|| hit(moving & minus_dir, dir_minus_il)));
		pct_main   = ovr_pct(i_feed_override_n);
		pct_fine   = FINE_OVR_FITTED ? ovr_pct(i_fine_override_n) : {1'b0, PCT_FULL};
		ovr_zero   = (pct_main == 8'h00) || (pct_fine == 8'h00);
		start_lock = cfg_ff[CFG_TURNING] && i_start_byte[BIT_START_LOCK];
		in_pos     = !motion_ff[MOTION_POSITIONING] || (i_pos_error <= inpos_ff);
		dwell_busy = dwell_ff != 32'h0;
		speed_wait = cfg_ff[CFG_ARRIVAL_EN] && !i_spindle_byte[BIT_AT_SPEED];
		detach_wait = hit(moving, detached_ff);
		wait_vec   = {detach_wait, speed_wait, start_lock, il_halt, ovr_zero, !in_pos, dwell_busy, hs.busy};
	end

	// ----------------------------------------------------------------
	// block sequencer
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state   = state_ff;
		nxt_advance = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				if (start_req && !start_lock) begin
					nxt_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (wait_vec == 8'h00) begin
					nxt_state   = ST_ADV;
					nxt_advance = 1'b1;
				end
			end
			ST_ADV: begin
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
		nxt_hold = il_halt || ovr_zero;
		nxt_strobe_byte = 8'h00;
		nxt_strobe_byte[BIT_M] = hs.strobe[AUX_M];
		nxt_strobe_byte[BIT_S] = hs.strobe[AUX_S];
		nxt_strobe_byte[BIT_T] = hs.strobe[AUX_T];
		if (cfg_ff[CFG_TURNING]) begin
			nxt_strobe_byte[BIT_B_TURN] = hs.strobe[AUX_B];
		end else begin
			nxt_strobe_byte[BIT_B_MILL] = hs.strobe[AUX_B];
		end
		nxt_multi_byte = 8'h00;
		nxt_multi_byte[BIT_M2] = hs.strobe[AUX_M2];
		nxt_multi_byte[BIT_M3] = hs.strobe[AUX_M3];
		nxt_detached = 8'h00;
		if (cfg_ff[CFG_DETACH_EN]) begin
			nxt_detached = (i_axis_detach_req | detach_par_ff) & axis_mask;
		end
		nxt_scaled = 32'((32'(feed_ff) * 32'(pct_main) * 32'(pct_fine)) / 32'd10000);
	end

	// register sequencer and pin outputs
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_ff       <= ST_IDLE;
			advance_ff     <= 1'b0;
			hold_ff        <= 1'b0;
			strobe_byte_ff <= 8'h00;
			multi_byte_ff  <= 8'h00;
			detached_ff    <= 8'h00;
			scaled_ff      <= 32'h0;
		end else begin
			state_ff       <= nxt_state;
			advance_ff     <= nxt_advance;
			hold_ff        <= nxt_hold;
			strobe_byte_ff <= nxt_strobe_byte;
			multi_byte_ff  <= nxt_multi_byte;
			detached_ff    <= nxt_detached;
			scaled_ff      <= nxt_scaled;
		end
	end

	// ----------------------------------------------------------------
	// apb register file
	// ----------------------------------------------------------------
	// answer comes one cycle into the access phase
	assign wr_en     = i_psel && i_penable && i_pwrite && !pready_ff;
	assign rd_en     = i_psel && i_penable && !i_pwrite && !pready_ff;
	assign start_req = wr_en && (i_paddr == OFS_CMD) && i_pwdata[CMD_START];

	always_comb begin
		nxt_cfg        = cfg_ff;
		nxt_dwell      = dwell_busy ? dwell_ff - 32'h1 : dwell_ff;
		nxt_inpos      = inpos_ff;
		nxt_motion     = motion_ff;
		nxt_detach_par = detach_par_ff;
		nxt_feed       = feed_ff;
		nxt_issue      = 6'h00;
		nxt_pready     = i_psel && i_penable && !pready_ff;
		nxt_pslverr    = 1'b0;
		nxt_prdata     = 32'h0;
		if (wr_en) begin
			if (i_paddr == OFS_CONFIG) begin
				nxt_cfg = i_pwdata[11:0];
			end else if (i_paddr == OFS_CMD) begin
				nxt_issue = i_pwdata[5:0];
			end else if (i_paddr == OFS_DWELL) begin
				nxt_dwell = i_pwdata;
			end else if (i_paddr == OFS_INPOS) begin
				nxt_inpos = i_pwdata[15:0];
			end else if (i_paddr == OFS_MOTION) begin
				nxt_motion = i_pwdata[16:0];
			end else if (i_paddr == OFS_DETACH) begin
				// each axis parameter keeps its detach bit at bit 3 of a nibble lane
				nxt_detach_par = {i_pwdata[31], i_pwdata[27], i_pwdata[23], i_pwdata[19],
					i_pwdata[15], i_pwdata[11], i_pwdata[DETACH_PARAM_BIT], i_pwdata[3]};
			end else if (i_paddr == OFS_FEED) begin
				nxt_feed = i_pwdata[15:0];
			end else if (i_paddr != OFS_STATUS && i_paddr != OFS_SCALED) begin
				nxt_pslverr = 1'b1;
			end else begin
				nxt_pslverr = 1'b1;
			end
		end else if (rd_en) begin
			if (i_paddr == OFS_CONFIG) begin
				nxt_prdata = {20'h0, cfg_ff};
			end else if (i_paddr == OFS_DWELL) begin
				nxt_prdata = dwell_ff;
			end else if (i_paddr == OFS_INPOS) begin
				nxt_prdata = {16'h0, inpos_ff};
			end else if (i_paddr == OFS_MOTION) begin
				nxt_prdata = {15'h0, motion_ff};
			end else if (i_paddr == OFS_DETACH) begin
				nxt_prdata = {24'h0, detach_par_ff};
			end else if (i_paddr == OFS_STATUS) begin
				nxt_prdata = {detached_ff, pct_main, 6'h0, state_ff, wait_vec};
			end else if (i_paddr == OFS_FEED) begin
				nxt_prdata = {pct_fine, 8'h0, feed_ff};
			end else if (i_paddr == OFS_SCALED) begin
				nxt_prdata = scaled_ff;
			end else if (i_paddr == OFS_CMD) begin
				nxt_prdata = 32'h0;
			end else begin
				nxt_pslverr = 1'b1;
			end
		end
	end

	// register the bus and register file
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cfg_ff        <= CFG_RESET;
			dwell_ff      <= 32'h0;
			inpos_ff      <= 16'h0;
			motion_ff     <= 17'h0;
			detach_par_ff <= 8'h00;
			feed_ff       <= 16'h0;
			issue_ff      <= 6'h00;
			pready_ff     <= 1'b0;
			pslverr_ff    <= 1'b0;
			prdata_ff     <= 32'h0;
		end else begin
			cfg_ff        <= nxt_cfg;
			dwell_ff      <= nxt_dwell;
			inpos_ff      <= nxt_inpos;
			motion_ff     <= nxt_motion;
			detach_par_ff <= nxt_detach_par;
			feed_ff       <= nxt_feed;
			issue_ff      <= nxt_issue;
			pready_ff     <= nxt_pready;
			pslverr_ff    <= nxt_pslverr;
			prdata_ff     <= nxt_prdata;
		end
	end

	assign o_pready             = pready_ff;
	assign o_prdata             = prdata_ff;
	assign o_pslverr            = pslverr_ff;
	assign o_strobe_byte        = strobe_byte_ff;
	assign o_multi_strobe_byte  = multi_byte_ff;
	assign o_axis_detached_flag = detached_ff;
	assign o_block_advance      = advance_ff;
	assign o_motion_hold        = hold_ff;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_waiting;
		state_ff == ST_WAIT && wait_vec == 8'h00;
	endsequence

	a_adv_after_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_waiting |=> o_block_advance ##1 (state_ff == ST_IDLE))
		else $error("advance not issued after waits cleared");
	a_no_adv_waiting: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(state_ff == ST_WAIT && wait_vec != 8'h00) |=> !o_block_advance)
		else $error("advance issued while a wait stands");
	a_dwell_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(state_ff == ST_WAIT && dwell_ff > 32'h1) |=> state_ff == ST_WAIT)
		else $error("block left during dwell");
	a_ovr_zero_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_feed_override_n == OVR_ALL_ONES || i_feed_override_n == OVR_ZERO) |=> o_motion_hold)
		else $error("zero override did not hold motion");
	a_global_il: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!cfg_ff[CFG_GLOBAL_IL_DIS] && !i_interlock_byte[BIT_GLOBAL_IL]) |=> o_motion_hold)
		else $error("global interlock did not hold motion");
	a_start_lock: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(state_ff == ST_IDLE && start_lock) |=> state_ff == ST_IDLE)
		else $error("start taken under start lock");
	a_detach_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!cfg_ff[CFG_DETACH_EN] |=> o_axis_detached_flag == 8'h00)
		else $error("detach reported while disabled");
	a_b_strobe_lane: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(cfg_ff[CFG_TURNING] && hs.strobe[AUX_B]) |=> o_strobe_byte[BIT_B_TURN] && !o_strobe_byte[BIT_B_MILL])
		else $error("turning b strobe on wrong bit");
	a_speed_wait: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(cfg_ff[CFG_ARRIVAL_EN] && !i_spindle_byte[BIT_AT_SPEED]) |-> wait_vec[6])
		else $error("spindle arrival wait missing");
endmodule

// ===== dv/machine_logic_model.sv
// machine side logic model: answers the aux code strobes of the gate
// assumes strobes are registered on i_clk and i_fast follows the config word
module machine_logic_model (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	// handshake mode
	input  wire logic       i_fast,
	input  wire logic       i_turning,
	// strobes from the gate
	input  wire logic [7:0] i_strobe_byte,
	input  wire logic [7:0] i_multi_strobe_byte,
	// completions to the gate
	output logic            o_aux_done_normal,
	output logic [7:0]      o_code_done_byte,
	output logic [7:0]      o_multi_done_byte
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] echo_ff;
	logic [7:0] mecho_ff;
	logic [2:0] cnt_ff;
	logic       clr_ff;
	// fast answer one cycle late, normal finish high four cycles then low
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			echo_ff <= 8'h00;
			mecho_ff <= 8'h00;
			cnt_ff <= 3'h0;
			clr_ff <= 1'b0;
			o_aux_done_normal <= 1'b0;
		end else begin
			echo_ff <= i_strobe_byte;
			mecho_ff <= i_multi_strobe_byte;
			if (cnt_ff != 3'h0) begin
				cnt_ff <= (cnt_ff == 3'h4) ? 3'h0 : cnt_ff + 3'h1;
				o_aux_done_normal <= (cnt_ff != 3'h4);
				clr_ff <= (cnt_ff == 3'h4);
			end else if (!i_fast && !clr_ff && (i_strobe_byte | i_multi_strobe_byte) != 8'h00) begin
				o_aux_done_normal <= 1'b1;
				cnt_ff <= 3'h1;
			end else if (clr_ff && (i_strobe_byte | i_multi_strobe_byte) == 8'h00) begin
				clr_ff <= 1'b0;
			end
		end
	end
	// unused bits carry the inverse so stale levels never match
	assign o_code_done_byte = {~echo_ff[7:5], i_turning ? echo_ff[4] : echo_ff[7], echo_ff[3:2], ~echo_ff[1],
		echo_ff[0]};
	assign o_multi_done_byte = {~mecho_ff[7:6], mecho_ff[5:4], ~mecho_ff[3:0]};
endmodule

// ===== dv/tb.sv
// testbench of the block advance gate: apb tasks and directed checks
// assumes the machine logic model answers every strobe
module tb
	import block_advance_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fast = 1'b0, turn = 1'b0;
	logic [7:0]  paddr = 8'h00, stl = 8'h00, feed = 8'h9B, ilk = 8'h01, axil = 8'hFF, dp = 8'h00;
	logic [7:0]  dreq = 8'h00, spd = 8'h00, tdir = 8'h00;
	logic [15:0] perr = 16'h0000;
	logic [31:0] pwdata = 32'h0, q;
	logic        e, man = 1'b0;
	logic        pready, pslverr, aux_done_normal, adv, hold;
	logic [31:0] prdata;
	logic [7:0]  stb, mstb, dfl, cdn, mdn;
	int          num_errors = 0, compares = 0;
	// 250 MHz clock
	always #2 clk = ~clk;
	block_advance_gate block_advance_gate_inst (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
		.o_pslverr(pslverr), .i_aux_done_normal(aux_done_normal), .i_code_done_byte(cdn), .i_multi_done_byte(mdn),
		.i_start_byte(stl), .i_feed_override_n(feed), .i_fine_override_n(8'h9B), .i_interlock_byte(ilk),
		.i_axis_interlock_n(axil), .i_dir_plus_byte(dp), .i_dir_minus_byte(8'h00), .i_turn_dir_byte(tdir),
		.i_axis_detach_req(dreq), .i_spindle_byte(spd), .i_manual_mode(man), .i_pos_error(perr),
		.o_strobe_byte(stb), .o_multi_strobe_byte(mstb), .o_axis_detached_flag(dfl), .o_block_advance(adv),
		.o_motion_hold(hold));
	machine_logic_model machine_logic_model_inst (.i_clk(clk), .i_rst_n(rst_n), .i_fast(fast), .i_turning(turn),
		.i_strobe_byte(stb), .i_multi_strobe_byte(mstb), .o_aux_done_normal(aux_done_normal), .o_code_done_byte(cdn),
		.o_multi_done_byte(mdn));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("errors=%0d compares=%0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// pready, prdata and pslverr are read as they stood at the edge
		for (n = 0; n < 40; n++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 40) begin
			num_errors++;
			end_of_test();
		end
	endtask
	task automatic cfg(input logic [31:0] v);
		apb(1'b1, OFS_CONFIG, v);
		fast <= v[CFG_FAST_SEL];
		turn <= v[CFG_TURNING];
	endtask
	// waits for a byte output: 0 strobes, 1 extra strobes, 2 detach flags
	task automatic see(input int s, input logic [7:0] x);
		int n;
		logic [7:0] g;
		for (n = 0; n < 30; n++) begin
			@(negedge clk);
			g = (s == 0) ? stb : (s == 1) ? mstb : dfl;
			if (g === x) break;
		end
		chk({24'h0, g}, {24'h0, x});
	endtask
	task automatic advq(input int n, input logic x);
		logic s;
		s = 1'b0;
		repeat (n) begin
			@(negedge clk);
			if (adv === 1'b1) s = 1'b1;
		end
		chk({31'h0, s}, {31'h0, x});
	endtask
	task automatic holdq(input logic x);
		repeat (6) @(negedge clk);
		chk({31'h0, hold}, {31'h0, x});
	endtask
	// bound on the whole run
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		end_of_test();
	end
	// main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, OFS_CONFIG, 32'h0);
		chk(q, {20'h0, CFG_RESET});
		apb(1'b0, 8'h3C, 32'h0);
		chk({q[31:1], e}, 32'h1);
		apb(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
		chk({31'h0, e}, 32'h1);
		@(posedge clk) feed <= 8'hFF;
		holdq(1'b1);
		@(posedge clk) feed <= 8'h01;
		holdq(1'b0);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk({24'h0, q[23:16]}, 32'hFE);
		@(posedge clk) feed <= 8'h00;
		holdq(1'b1);
		@(posedge clk) feed <= 8'h9B;
		holdq(1'b0);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk({24'h0, q[23:16]}, {24'h0, 1'b0, PCT_FULL});
		apb(1'b1, OFS_CMD, 32'h1);
		see(0, 8'h01);
		see(0, 8'h00);
		apb(1'b1, OFS_CMD, 32'h100);
		advq(20, 1'b1);
		cfg(32'h80);
		apb(1'b1, OFS_CMD, 32'h3F);
		see(0, 8'h8D);
		chk({24'h0, mstb}, 32'h0);
		apb(1'b1, OFS_CMD, 32'h100);
		advq(30, 1'b1);
		apb(1'b1, OFS_CMD, 32'h0F);
		see(0, 8'h00);
		cfg(32'h880);
		apb(1'b1, OFS_CMD, 32'h08);
		see(0, 8'h10);
		@(posedge clk) stl <= 8'h02;
		apb(1'b1, OFS_CMD, 32'h100);
		advq(20, 1'b0);
		@(posedge clk) stl <= 8'h00;
		apb(1'b1, OFS_CMD, 32'h100);
		advq(30, 1'b1);
		cfg(32'h180);
		apb(1'b1, OFS_CMD, 32'h10);
		see(1, 8'h10);
		apb(1'b1, OFS_DWELL, 32'd40);
		apb(1'b1, OFS_CMD, 32'h100);
		advq(10, 1'b0);
		advq(60, 1'b1);
		cfg(32'h580);
		apb(1'b1, OFS_CMD, 32'h100);
		advq(20, 1'b0);
		@(posedge clk) spd <= 8'h10;
		advq(20, 1'b1);
		cfg(32'h80);
		apb(1'b1, OFS_MOTION, 32'h1);
		@(posedge clk) ilk <= 8'h00;
		holdq(1'b1);
		@(posedge clk) ilk <= 8'h01;
		axil <= 8'hFE;
		holdq(1'b1);
		@(posedge clk) axil <= 8'hFF;
		dp <= 8'h01;
		holdq(1'b1);
		cfg(32'h8D);
		holdq(1'b0);
		cfg(32'h280);
		@(posedge clk) dreq <= 8'h04;
		see(2, 8'h04);
		@(posedge clk) dreq <= 8'h00;
		apb(1'b1, OFS_DETACH, 32'h80);
		see(2, 8'h02);
		cfg(32'h880);
		@(posedge clk) tdir <= 8'h04;
		holdq(1'b0);
		@(posedge clk) man <= 1'b1;
		holdq(1'b1);
		apb(1'b1, OFS_INPOS, 32'h4);
		apb(1'b1, OFS_MOTION, 32'h10000);
		@(posedge clk) perr <= 16'h000A;
		apb(1'b1, OFS_CMD, 32'h100);
		advq(20, 1'b0);
		@(posedge clk) perr <= 16'h0003;
		advq(20, 1'b1);
		end_of_test();
	end
endmodule
